//--- rtfc_top.sv
// Remap table fault checker: mode, root and context entry checks
`timescale 1ns/10ps
module rtfc_top #(
  parameter bit SCALABLE_MODE_SUPPORTED = 1'b1,
  parameter int COUNT_W                 = 16
) (
  input  wire logic                core_clk_in,
  input  wire logic                rst_in,
  // Avalon-MM slave
  input  wire logic [4:0]          avs_address_in,
  input  wire logic                avs_read_in,
  input  wire logic                avs_write_in,
  input  wire logic [31:0]         avs_writedata_in,
  input  wire logic [3:0]          avs_byteenable_in,
  output logic      [31:0]         avs_readdata_out,
  output logic                     avs_waitrequest_out,
  // Request and fetched table state
  input  wire logic                req_valid_in,
  input  rtfc_pkg::rtfc_req_t      req_kind_in,
  input  wire logic                req_pasid_in,
  input  wire logic                req_needs_resp_in,
  input  wire logic                root_fetch_err_in,
  input  wire logic                use_upper_half_in,
  input  wire logic                lower_half_present_in,
  input  wire logic                upper_half_present_in,
  input  wire logic                lower_half_rsvd_nz_in,
  input  wire logic                upper_half_rsvd_nz_in,
  input  wire logic                ctx_fetch_err_in,
  input  wire logic                ctx_present_in,
  input  wire logic                ctx_rsvd_nz_in,
  input  wire logic                device_tlb_enable_in,
  input  wire logic                page_req_enable_in,
  // Verdict
  output logic                     rsp_valid_out,
  output rtfc_pkg::rtfc_rsp_t      rsp_code_out,
  output logic                     fault_out,
  output logic [7:0]               fault_reason_out,
  output logic                     fault_qualified_out,
  output logic                     irq_out
);
  import rtfc_pkg::*;

  localparam logic [COUNT_W-1:0] CNT_MAX  = {COUNT_W{1'b1}};
  localparam logic [COUNT_W-1:0] CNT_ZERO = '0;
  localparam logic [COUNT_W-1:0] CNT_ONE  = {{(COUNT_W-1){1'b0}}, 1'b1};

  // Software state
  logic [1:0]             table_mode_field;
  logic [RTFC_ST_W-1:0]   status;
  logic [RTFC_ST_W-1:0]   mask;
  logic [COUNT_W-1:0]     fault_count;
  logic [7:0]             last_reason;
  logic                   last_qual;
  rtfc_rsp_t              last_rsp;
  rtfc_req_t              last_kind;

  // Checker verdict for the current request
  logic                   next_fault;
  logic [7:0]             next_reason;
  logic                   next_qual;
  logic                   next_mode_fault;
  rtfc_class_t            next_class;
  logic [RTFC_ST_W-1:0]   next_status;
  logic [RTFC_ST_W-1:0]   set_bits;
  logic                   root_sel_present;
  logic                   root_rsvd_hit;
  logic                   pasid_dma;

  // Bus decode
  logic                   bus_access;
  logic                   bus_write;
  logic                   bus_read;
  logic                   status_read;
  logic [31:0]            next_readdata;

  rtfc_sel_if sel_if ();

  rtfc_resp_sel u_resp_sel (
    .sel_if (sel_if.sel)
  );

  assign sel_if.kind       = req_kind_in;
  assign sel_if.needs_resp = req_needs_resp_in;
  assign sel_if.fclass     = next_class;

  // Root-entry and legacy PASID helper terms
  assign root_sel_present = use_upper_half_in ? upper_half_present_in
                                              : lower_half_present_in;
  assign root_rsvd_hit    = (lower_half_present_in && lower_half_rsvd_nz_in) ||
                            (upper_half_present_in && upper_half_rsvd_nz_in);
  assign pasid_dma        = req_pasid_in &&
                            ((req_kind_in == RQ_UNTRANS) || (req_kind_in == RQ_TRANSLATION));

  // Fault priority follows the table walk; first hit wins
  always_comb
  begin
    next_fault      = 1'b1;
    next_reason     = RTFC_RSN_NONE;
    next_qual       = 1'b0;
    next_mode_fault = 1'b0;
    next_class      = FC_STD;
    if (table_mode_field == RTFC_MODE_BAD_11)
    begin
      next_reason     = RTFC_RSN_BAD_MODE;
      next_mode_fault = 1'b1;
    end
    else if (table_mode_field == RTFC_MODE_BAD_10)
    begin
      next_reason     = RTFC_RSN_BAD_MODE;
      next_mode_fault = 1'b1;
    end
    else if ((table_mode_field == RTFC_MODE_SCALABLE) && !SCALABLE_MODE_SUPPORTED)
    begin
      next_reason     = RTFC_RSN_BAD_MODE;
      next_mode_fault = 1'b1;
    end
    else if (table_mode_field == RTFC_MODE_LEGACY)
    begin
      // Legacy walk checks live elsewhere; only PASID and page use is caught
      next_class = FC_LEGACY;
      if (req_kind_in == RQ_PAGE)
      begin
        next_reason = RTFC_RSN_LEG_PAGE;
      end
      else if (pasid_dma)
      begin
        next_reason = RTFC_RSN_LEG_PASID;
      end
      else
      begin
        next_fault = 1'b0;
        next_class = FC_NONE;
      end
    end
    else if (root_fetch_err_in)
    begin
      next_reason = RTFC_RSN_ROOT_ERR;
    end
    else if (!root_sel_present)
    begin
      next_reason = RTFC_RSN_ROOT_NP;
      next_class  = FC_ALL_UR;
    end
    else if (root_rsvd_hit)
    begin
      next_reason = RTFC_RSN_ROOT_RSV;
    end
    else if (ctx_fetch_err_in)
    begin
      next_reason = RTFC_RSN_CTX_ERR;
    end
    else if (!ctx_present_in)
    begin
      next_reason = RTFC_RSN_CTX_NP;
      next_qual   = 1'b1;
      next_class  = FC_ALL_UR;
    end
    else if (ctx_rsvd_nz_in)
    begin
      next_reason = RTFC_RSN_CTX_RSV;
      next_qual   = 1'b1;
    end
    else if (!device_tlb_enable_in && page_req_enable_in)
    begin
      next_reason = RTFC_RSN_CTX_CONF;
      next_qual   = 1'b1;
    end
    else
    begin
      next_fault = 1'b0;
      next_class = FC_NONE;
    end
  end

  // Verdict registered one cycle after the request
  always_ff @(posedge core_clk_in)
  begin
    if (rst_in)
    begin
      rsp_valid_out       <= 1'b0;
      rsp_code_out        <= RSP_PASS;
      fault_out           <= 1'b0;
      fault_reason_out    <= RTFC_RSN_NONE;
      fault_qualified_out <= 1'b0;
    end
    else
    begin
      rsp_valid_out <= req_valid_in;
      if (req_valid_in)
      begin
        rsp_code_out        <= sel_if.rsp;
        fault_out           <= next_fault;
        fault_reason_out    <= next_reason;
        fault_qualified_out <= next_qual;
      end
      else
      begin
        fault_out <= 1'b0;
      end
    end
  end

  // Last fault snapshot for software
  always_ff @(posedge core_clk_in)
  begin
    if (rst_in)
    begin
      last_reason <= RTFC_RSN_NONE;
      last_qual   <= 1'b0;
      last_rsp    <= RSP_PASS;
      last_kind   <= RQ_UNTRANS;
    end
    else if (req_valid_in && next_fault)
    begin
      last_reason <= next_reason;
      last_qual   <= next_qual;
      last_rsp    <= sel_if.rsp;
      last_kind   <= req_kind_in;
    end
  end

  // Saturating fault counter; a stuck source cannot wrap it back to zero
  always_ff @(posedge core_clk_in)
  begin
    if (rst_in)
    begin
      fault_count <= CNT_ZERO;
    end
    else if (req_valid_in && next_fault && (fault_count != CNT_MAX))
    begin
      fault_count <= fault_count + CNT_ONE;
    end
    else if (bus_write && (avs_address_in == RTFC_OFF_COUNT))
    begin
      fault_count <= CNT_ZERO;
    end
  end

  // Bus strobes; reads load on the request edge, writes land on the ack edge
  assign bus_access  = (avs_read_in || avs_write_in) && avs_waitrequest_out;
  assign bus_write   = avs_write_in && !avs_waitrequest_out;
  assign bus_read    = avs_read_in && avs_waitrequest_out;
  assign status_read = bus_read && (avs_address_in == RTFC_OFF_STATUS);

  // Sticky events; a new event beats the clear-on-read
  assign set_bits[RTFC_ST_FAULT] = req_valid_in && next_fault;
  assign set_bits[RTFC_ST_NONQ]  = req_valid_in && next_fault && !next_qual;
  assign set_bits[RTFC_ST_QUAL]  = req_valid_in && next_fault && next_qual;
  assign set_bits[RTFC_ST_MODE]  = req_valid_in && next_mode_fault;
  assign next_status = (status_read ? '0 : status) | set_bits;

  always_ff @(posedge core_clk_in)
  begin
    if (rst_in)
    begin
      status <= '0;
    end
    else
    begin
      status <= next_status;
    end
  end

  // Level interrupt from unmasked sticky bits
  always_ff @(posedge core_clk_in)
  begin
    if (rst_in)
    begin
      irq_out <= 1'b0;
    end
    else
    begin
      irq_out <= |(next_status & mask);
    end
  end

  // Writable control and mask; only byte lane 0 carries fields
  always_ff @(posedge core_clk_in)
  begin
    if (rst_in)
    begin
      table_mode_field <= RTFC_CTRL_RESET;
      mask             <= RTFC_MASK_RESET;
    end
    else if (bus_write && avs_byteenable_in[0])
    begin
      if (avs_address_in == RTFC_OFF_CTRL)
      begin
        table_mode_field <= avs_writedata_in[RTFC_CTRL_MODE_LSB +: 2];
      end
      if (avs_address_in == RTFC_OFF_MASK)
      begin
        mask <= avs_writedata_in[RTFC_ST_W-1:0];
      end
    end
  end

  // Read mux; unmapped offsets read as zero
  always_comb
  begin
    next_readdata = 32'h0000_0000;
    case (avs_address_in)
      RTFC_OFF_CTRL:
        next_readdata[RTFC_CTRL_MODE_LSB +: 2] = table_mode_field;
      RTFC_OFF_STATUS:
        next_readdata[RTFC_ST_W-1:0] = status;
      RTFC_OFF_MASK:
        next_readdata[RTFC_ST_W-1:0] = mask;
      RTFC_OFF_LAST:
      begin
        next_readdata[7:0]                    = last_reason;
        next_readdata[RTFC_LAST_QUAL_BIT]     = last_qual;
        next_readdata[RTFC_LAST_RSP_LSB +: 3] = last_rsp;
        next_readdata[RTFC_LAST_KIND_LSB +: 2] = last_kind;
      end
      RTFC_OFF_CAP:
        next_readdata[0] = SCALABLE_MODE_SUPPORTED;
      RTFC_OFF_COUNT:
        next_readdata[COUNT_W-1:0] = fault_count;
      default:
        next_readdata = 32'h0000_0000;
    endcase
  end

  // One wait state per access; readdata loads with the ack
  always_ff @(posedge core_clk_in)
  begin
    if (rst_in)
    begin
      avs_waitrequest_out <= 1'b1;
      avs_readdata_out    <= 32'h0000_0000;
    end
    else
    begin
      avs_waitrequest_out <= !bus_access;
      if (bus_read)
      begin
        avs_readdata_out <= next_readdata;
      end
    end
  end

endmodule

//--- rtfc_pkg.sv
// Package of constants and types for the remap table fault checker
package rtfc_pkg;

  // Register byte offsets on the Avalon-MM slave
  localparam logic [4:0] RTFC_OFF_CTRL   = 5'h00;
  localparam logic [4:0] RTFC_OFF_STATUS = 5'h04;
  localparam logic [4:0] RTFC_OFF_MASK   = 5'h08;
  localparam logic [4:0] RTFC_OFF_LAST   = 5'h0C;
  localparam logic [4:0] RTFC_OFF_CAP    = 5'h10;
  localparam logic [4:0] RTFC_OFF_COUNT  = 5'h14;

  // Control register: table_mode_field in bits 1:0
  localparam int         RTFC_CTRL_MODE_LSB = 0;
  localparam logic [1:0] RTFC_CTRL_RESET    = 2'h0;

  // Table mode encodings
  localparam logic [1:0] RTFC_MODE_LEGACY   = 2'h0;
  localparam logic [1:0] RTFC_MODE_SCALABLE = 2'h1;
  localparam logic [1:0] RTFC_MODE_BAD_10   = 2'h2;
  localparam logic [1:0] RTFC_MODE_BAD_11   = 2'h3;

  // Status and mask bit positions
  localparam int RTFC_ST_FAULT = 0;
  localparam int RTFC_ST_NONQ  = 1;
  localparam int RTFC_ST_QUAL  = 2;
  localparam int RTFC_ST_MODE  = 3;
  localparam int RTFC_ST_W     = 4;
  localparam logic [3:0] RTFC_MASK_RESET = 4'h0;

  // Last-fault register field positions
  localparam int RTFC_LAST_QUAL_BIT = 8;
  localparam int RTFC_LAST_RSP_LSB  = 9;
  localparam int RTFC_LAST_KIND_LSB = 12;

  // Fault reason codes
  localparam logic [7:0] RTFC_RSN_NONE      = 8'h00;
  localparam logic [7:0] RTFC_RSN_BAD_MODE  = 8'h30;
  localparam logic [7:0] RTFC_RSN_LEG_PASID = 8'h31;
  localparam logic [7:0] RTFC_RSN_LEG_PAGE  = 8'h32;
  localparam logic [7:0] RTFC_RSN_ROOT_ERR  = 8'h38;
  localparam logic [7:0] RTFC_RSN_ROOT_NP   = 8'h39;
  localparam logic [7:0] RTFC_RSN_ROOT_RSV  = 8'h3A;
  localparam logic [7:0] RTFC_RSN_CTX_ERR   = 8'h40;
  localparam logic [7:0] RTFC_RSN_CTX_NP    = 8'h41;
  localparam logic [7:0] RTFC_RSN_CTX_RSV   = 8'h42;
  localparam logic [7:0] RTFC_RSN_CTX_CONF  = 8'h43;

  // Request kinds arriving from the device side
  typedef enum logic [1:0] {
    RQ_UNTRANS,
    RQ_TRANSLATION,
    RQ_TRANSLATED,
    RQ_PAGE
  } rtfc_req_t;

  // Response pattern of a detected fault
  typedef enum logic [1:0] {
    FC_NONE,
    FC_STD,
    FC_ALL_UR,
    FC_LEGACY
  } rtfc_class_t;

  // Response chosen for a request
  typedef enum logic [2:0] {
    RSP_PASS,
    RSP_UR,
    RSP_CA,
    RSP_IR,
    RSP_DROP
  } rtfc_rsp_t;

endpackage

//--- rtfc_sel_if.sv
// Interface between the fault checker and its response selector
`timescale 1ns/10ps
interface rtfc_sel_if;
  import rtfc_pkg::*;
  rtfc_req_t   kind;
  logic        needs_resp;
  rtfc_class_t fclass;
  rtfc_rsp_t   rsp;

  modport chk (output kind, output needs_resp, output fclass, input rsp);
  modport sel (input kind, input needs_resp, input fclass, output rsp);
endinterface

//--- rtfc_resp_sel.sv
// Response selector: fault class and request kind to response
`timescale 1ns/10ps
module rtfc_resp_sel (
  rtfc_sel_if.sel sel_if
);
  import rtfc_pkg::*;

  // Page requests share one answer for every fault class
  always_comb
  begin
    sel_if.rsp = RSP_PASS;
    if (sel_if.fclass != FC_NONE)
    begin
      case (sel_if.kind)
        RQ_PAGE:
          sel_if.rsp = sel_if.needs_resp ? RSP_IR : RSP_DROP;
        RQ_TRANSLATION:
          sel_if.rsp = (sel_if.fclass == FC_STD) ? RSP_CA : RSP_UR;
        RQ_UNTRANS,
        RQ_TRANSLATED:
          sel_if.rsp = RSP_UR;
        default:
          sel_if.rsp = RSP_UR;
      endcase
    end
  end

endmodule

//--- rtfc_ep_model.sv
// Endpoint-side model issuing requests with their fetched table state
`timescale 1ns/10ps
module rtfc_ep_model (
  input  wire logic        clk_in,
  input  wire logic        issue_in,
  input  wire logic [14:0] cmd_in,
  output logic             req_valid_out = 1'b0,
  output logic [14:0]      req_out = 15'h0000
);
  // One cycle per issue; idle qualifiers flip so stale values never pass
  always @(posedge clk_in)
  begin
    req_valid_out <= issue_in;
    req_out       <= issue_in ? cmd_in : ~req_out;
  end
endmodule

//--- rtfc_monitor.sv
// Concurrent checks on the fault checker's ports
`timescale 1ns/10ps
module rtfc_monitor (
  input wire logic           core_clk_in,
  input wire logic           rst_in,
  input wire logic           req_valid_in,
  input rtfc_pkg::rtfc_req_t req_kind_in,
  input wire logic           req_needs_resp_in,
  input wire logic           root_fetch_err_in,
  input wire logic           use_upper_half_in,
  input wire logic           lower_half_present_in,
  input wire logic           upper_half_present_in,
  input wire logic           ctx_fetch_err_in,
  input wire logic           ctx_present_in,
  input wire logic           device_tlb_enable_in,
  input wire logic           page_req_enable_in,
  input wire logic           rsp_valid_out,
  input rtfc_pkg::rtfc_rsp_t rsp_code_out,
  input wire logic           fault_out,
  input wire logic [7:0]     fault_reason_out,
  input wire logic           fault_qualified_out
);
  import rtfc_pkg::*;
  default clocking @(posedge core_clk_in);
  endclocking
  default disable iff (rst_in);
  // Request of one kind, then an answer carrying one reason
  sequence s_req(rtfc_req_t k);
    req_valid_in && req_kind_in == k;
  endsequence
  sequence s_rsn(logic [7:0] r);
    rsp_valid_out && fault_reason_out == r;
  endsequence
  property p_answer;
    req_valid_in |=> rsp_valid_out && fault_out == (fault_reason_out != 8'h00);
  endproperty
  a_answer: assert property (p_answer)
    else $error("request not answered next cycle");
  property p_quiet;
    !req_valid_in |=> !rsp_valid_out && !fault_out;
  endproperty
  a_quiet: assert property (p_quiet)
    else $error("answer without request");
  property p_page;
    s_req(RQ_PAGE) |=> rsp_code_out ==
      (!fault_out ? RSP_PASS : ($past(req_needs_resp_in) ? RSP_IR : RSP_DROP));
  endproperty
  a_page: assert property (p_page)
    else $error("page request answer wrong");
  property p_xlat;
    s_req(RQ_TRANSLATION) |=> (rsp_code_out == RSP_CA) ==
      (fault_reason_out inside {8'h30, 8'h38, 8'h3A, 8'h40, 8'h42, 8'h43});
  endproperty
  a_xlat: assert property (p_xlat)
    else $error("translation abort choice wrong");
  property p_root_err;
    s_rsn(8'h38) |-> $past(root_fetch_err_in) && !fault_qualified_out;
  endproperty
  a_root_err: assert property (p_root_err)
    else $error("root fetch reason without cause");
  property p_root_np;
    s_rsn(8'h39) |-> ($past(use_upper_half_in) ? !$past(upper_half_present_in)
      : !$past(lower_half_present_in));
  endproperty
  a_root_np: assert property (p_root_np)
    else $error("root absent reason with half present");
  property p_ctx_err;
    s_rsn(8'h40) |-> $past(ctx_fetch_err_in) && !$past(root_fetch_err_in);
  endproperty
  a_ctx_err: assert property (p_ctx_err)
    else $error("context fetch reason out of order");
  property p_ctx_np;
    s_rsn(8'h41) |-> fault_qualified_out && !$past(ctx_present_in);
  endproperty
  a_ctx_np: assert property (p_ctx_np)
    else $error("context absent reason wrong");
  property p_ctx_conf;
    s_rsn(8'h43) |-> fault_qualified_out && $past(page_req_enable_in)
      && !$past(device_tlb_enable_in);
  endproperty
  a_ctx_conf: assert property (p_ctx_conf)
    else $error("enable conflict reason wrong");
endmodule

bind rtfc_top rtfc_monitor mon (
  .core_clk_in(core_clk_in), .rst_in(rst_in), .req_valid_in(req_valid_in),
  .req_kind_in(req_kind_in), .req_needs_resp_in(req_needs_resp_in),
  .root_fetch_err_in(root_fetch_err_in), .use_upper_half_in(use_upper_half_in),
  .lower_half_present_in(lower_half_present_in),
  .upper_half_present_in(upper_half_present_in), .ctx_fetch_err_in(ctx_fetch_err_in),
  .ctx_present_in(ctx_present_in), .device_tlb_enable_in(device_tlb_enable_in),
  .page_req_enable_in(page_req_enable_in), .rsp_valid_out(rsp_valid_out),
  .rsp_code_out(rsp_code_out), .fault_out(fault_out), .fault_reason_out(fault_reason_out),
  .fault_qualified_out(fault_qualified_out)
);

//--- tb.sv
// Testbench: register access, fault classification and interrupt
`timescale 1ns/10ps
module tb;
  import rtfc_pkg::*;
  logic        core_clk_in, rst_in, avs_read_in, avs_write_in, avs_waitrequest_out;
  logic [4:0]  avs_address_in;
  logic [31:0] avs_writedata_in, avs_readdata_out, got;
  logic [3:0]  avs_byteenable_in;
  logic        req_valid_in, req_pasid_in, req_needs_resp_in, root_fetch_err_in;
  logic        use_upper_half_in, lower_half_present_in, upper_half_present_in;
  logic        lower_half_rsvd_nz_in, upper_half_rsvd_nz_in, ctx_fetch_err_in;
  logic        ctx_present_in, ctx_rsvd_nz_in, device_tlb_enable_in, page_req_enable_in;
  logic        rsp_valid_out, fault_out, fault_qualified_out, irq_out, issue;
  logic [7:0]  fault_reason_out;
  logic [14:0] cmd, rq;
  rtfc_req_t   req_kind_in;
  rtfc_rsp_t   rsp_code_out;
  rtfc_rsp_t   nosm_rsp;
  logic [31:0] nosm_readdata;
  logic [7:0]  nosm_reason;
  logic        nosm_qual;
  int          num_errors = 0;
  int          checked = 0;
  int          cyc = 0;

  rtfc_top dut (.*);
  // Same traffic, scalable mode reported absent
  rtfc_top #(.SCALABLE_MODE_SUPPORTED(1'b0)) dut_nosm (.*, .avs_readdata_out(nosm_readdata),
    .avs_waitrequest_out(), .rsp_valid_out(), .rsp_code_out(nosm_rsp), .fault_out(),
    .fault_reason_out(nosm_reason), .fault_qualified_out(nosm_qual), .irq_out());
  rtfc_ep_model ep (.clk_in(core_clk_in), .issue_in(issue), .cmd_in(cmd),
                    .req_valid_out(req_valid_in), .req_out(rq));
  // Unpack the model's request word
  assign req_kind_in = rtfc_req_t'(rq[14:13]);
  assign {req_pasid_in, req_needs_resp_in, root_fetch_err_in, use_upper_half_in,
          lower_half_present_in, upper_half_present_in, lower_half_rsvd_nz_in,
          upper_half_rsvd_nz_in, ctx_fetch_err_in, ctx_present_in, ctx_rsvd_nz_in,
          device_tlb_enable_in, page_req_enable_in} = rq[12:0];

  initial
  begin
    core_clk_in = 1'b0;
    forever #12.5 core_clk_in = ~core_clk_in;
  end

  task automatic close_out;
    begin
      if (num_errors == 0 && checked > 0)
        $display("DONE - PASS");
      else
        $display("DONE - FAIL");
      $finish;
    end
  endtask

  // Hang guard, far above the few hundred cycles the tests need
  always @(posedge core_clk_in)
  begin
    cyc <= cyc + 1;
    if (cyc == 3000)
    begin
      num_errors++;
      close_out();
    end
  end

  task automatic cmp_val(input logic [31:0] g, input logic [31:0] e);
    begin
      checked++;
      if (g !== e)
      begin
        num_errors++;
        $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
      end
    end
  endtask

  task automatic cmp_rsp(input rtfc_rsp_t g, input rtfc_rsp_t e);
    begin
      checked++;
      if (g !== e)
      begin
        num_errors++;
        $display("[FAIL] t=%0t rsp got=%h exp=%h", $time, g, e);
      end
    end
  endtask

  // Avalon-MM access: hold until waitrequest is sampled low
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    begin
      @(posedge core_clk_in);
      avs_read_in      <= !w;
      avs_write_in     <= w;
      avs_address_in   <= a;
      avs_writedata_in <= d;
      // No timeout here; a waitrequest stuck high is ended only by the hang guard
      do
      begin
        @(posedge core_clk_in);
      end
      while (avs_waitrequest_out !== 1'b0);
      got = avs_readdata_out;
      avs_read_in  <= 1'b0;
      avs_write_in <= 1'b0;
    end
  endtask

  task automatic rchk(input logic [4:0] a, input logic [31:0] e);
    begin
      bus(1'b0, a, 32'h0000_0000);
      cmp_val(got, e);
    end
  endtask

  // Set mode, issue one request, check the answer a cycle after it lands
  task automatic t(input logic [1:0] m, input rtfc_req_t k, input logic [1:0] pn,
                   input logic [10:0] x, input rtfc_rsp_t er, input logic [7:0] es,
                   input logic eq);
    begin
      bus(1'b1, RTFC_OFF_CTRL, {30'h0, m});
      @(posedge core_clk_in);
      issue <= 1'b1;
      cmd   <= {k, pn, 11'h18B ^ x};
      @(posedge core_clk_in);
      issue <= 1'b0;
      @(posedge core_clk_in);
      #1;
      cmp_rsp(rsp_code_out, er);
      cmp_val({21'h0, rsp_valid_out, fault_qualified_out, fault_out, fault_reason_out},
              {21'h0, 1'b1, eq, es != 8'h00, es});
    end
  endtask

  initial
  begin
    rst_in = 1'b1;
    avs_read_in = 1'b0;
    avs_write_in = 1'b0;
    avs_address_in = 5'h00;
    avs_writedata_in = 32'h0000_0000;
    avs_byteenable_in = 4'hF;
    issue = 1'b0;
    cmd = 15'h0000;
    repeat (10) @(posedge core_clk_in);
    rst_in <= 1'b0;
    // Reset values, read-only and unmapped places
    rchk(RTFC_OFF_CTRL, 32'h0000_0000);
    rchk(RTFC_OFF_MASK, 32'h0000_0000);
    bus(1'b1, RTFC_OFF_CAP, 32'h0000_0000);
    rchk(RTFC_OFF_CAP, 32'h0000_0001);
    cmp_val(nosm_readdata, 32'h0000_0000);
    rchk(5'h18, 32'h0000_0000);
    // Masked-in fault raises the interrupt; reading status drops it
    bus(1'b1, RTFC_OFF_MASK, 32'h0000_0004);
    // Lane 0 disabled: the write must not land
    avs_byteenable_in <= 4'hE;
    bus(1'b1, RTFC_OFF_MASK, 32'h0000_000F);
    avs_byteenable_in <= 4'hF;
    rchk(RTFC_OFF_MASK, 32'h0000_0004);
    t(2'h1, RQ_TRANSLATION, 2'b00, 11'h008, RSP_UR, 8'h41, 1'b1);
    cmp_val({31'h0, irq_out}, 32'h0000_0001);
    rchk(RTFC_OFF_LAST, 32'h0000_1341);
    rchk(RTFC_OFF_STATUS, 32'h0000_0005);
    #1;
    cmp_val({31'h0, irq_out}, 32'h0000_0000);
    t(2'h1, RQ_UNTRANS, 2'b10, 11'h400, RSP_UR, 8'h38, 1'b0);
    cmp_val({31'h0, irq_out}, 32'h0000_0000);
    rchk(RTFC_OFF_COUNT, 32'h0000_0002);
    bus(1'b1, RTFC_OFF_COUNT, 32'h0000_0000);
    rchk(RTFC_OFF_COUNT, 32'h0000_0000);
    // Invalid mode encodings
    t(2'h3, RQ_UNTRANS, 2'b10, 11'h000, RSP_UR, 8'h30, 1'b0);
    t(2'h3, RQ_TRANSLATION, 2'b00, 11'h000, RSP_CA, 8'h30, 1'b0);
    t(2'h3, RQ_TRANSLATED, 2'b00, 11'h000, RSP_UR, 8'h30, 1'b0);
    t(2'h3, RQ_PAGE, 2'b01, 11'h000, RSP_IR, 8'h30, 1'b0);
    t(2'h3, RQ_PAGE, 2'b00, 11'h000, RSP_DROP, 8'h30, 1'b0);
    t(2'h2, RQ_TRANSLATION, 2'b10, 11'h000, RSP_CA, 8'h30, 1'b0);
    t(2'h2, RQ_PAGE, 2'b01, 11'h000, RSP_IR, 8'h30, 1'b0);
    rchk(RTFC_OFF_STATUS, 32'h0000_000B);
    // Legacy mode: table state is ignored
    t(2'h0, RQ_UNTRANS, 2'b10, 11'h000, RSP_UR, 8'h31, 1'b0);
    t(2'h0, RQ_TRANSLATION, 2'b10, 11'h000, RSP_UR, 8'h31, 1'b0);
    t(2'h0, RQ_UNTRANS, 2'b00, 11'h7FF, RSP_PASS, 8'h00, 1'b0);
    t(2'h0, RQ_TRANSLATED, 2'b10, 11'h000, RSP_PASS, 8'h00, 1'b0);
    t(2'h0, RQ_PAGE, 2'b11, 11'h000, RSP_IR, 8'h32, 1'b0);
    t(2'h0, RQ_PAGE, 2'b00, 11'h000, RSP_DROP, 8'h32, 1'b0);
    // Scalable walk: each check in turn; where several faults meet, the first one wins
    t(2'h1, RQ_UNTRANS, 2'b10, 11'h000, RSP_PASS, 8'h00, 1'b0);
    t(2'h1, RQ_TRANSLATION, 2'b00, 11'h410, RSP_CA, 8'h38, 1'b0);
    t(2'h1, RQ_PAGE, 2'b00, 11'h400, RSP_DROP, 8'h38, 1'b0);
    t(2'h1, RQ_TRANSLATION, 2'b00, 11'h140, RSP_UR, 8'h39, 1'b0);
    t(2'h1, RQ_TRANSLATED, 2'b00, 11'h280, RSP_UR, 8'h39, 1'b0);
    t(2'h1, RQ_TRANSLATED, 2'b00, 11'h0A0, RSP_PASS, 8'h00, 1'b0);
    t(2'h1, RQ_TRANSLATION, 2'b00, 11'h040, RSP_CA, 8'h3A, 1'b0);
    cmp_val({23'h0, nosm_qual, nosm_reason}, 32'h0000_0030);
    cmp_rsp(nosm_rsp, RSP_CA);
    t(2'h1, RQ_PAGE, 2'b01, 11'h020, RSP_IR, 8'h3A, 1'b0);
    t(2'h1, RQ_TRANSLATED, 2'b00, 11'h018, RSP_UR, 8'h40, 1'b0);
    t(2'h1, RQ_TRANSLATION, 2'b00, 11'h00C, RSP_UR, 8'h41, 1'b1);
    t(2'h1, RQ_TRANSLATION, 2'b00, 11'h006, RSP_CA, 8'h42, 1'b1);
    t(2'h1, RQ_UNTRANS, 2'b00, 11'h002, RSP_UR, 8'h43, 1'b1);
    t(2'h1, RQ_TRANSLATION, 2'b00, 11'h002, RSP_CA, 8'h43, 1'b1);
    t(2'h1, RQ_PAGE, 2'b00, 11'h002, RSP_DROP, 8'h43, 1'b1);
    t(2'h1, RQ_TRANSLATION, 2'b00, 11'h003, RSP_PASS, 8'h00, 1'b0);
    close_out();
  end
endmodule
